// ===== design/core_pkg.sv
// shared constants and types for the core sequencer and register file
// assumes one 125 MHz clock and a synchronous active-high reset
`default_nettype none

package core_pkg;

    // ------------------------------------------------------------------
    // phase sequence
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_ONE   = 2'b00,
        PH_TWO   = 2'b01,
        PH_THREE = 2'b10,
        PH_FOUR  = 2'b11
    } phase_e;

    // ------------------------------------------------------------------
    // file addresses of the core registers (bank-free 7-bit form)
    // ------------------------------------------------------------------
    localparam logic [6:0] FA_INDIRECT = 7'h00;
    localparam logic [6:0] FA_PC_LOW = 7'h02;
    localparam logic [6:0] FA_CORE_STAT = 7'h03;
    localparam logic [6:0] FA_POINTER = 7'h04;
    localparam logic [6:0] FA_PC_HIGH = 7'h0A;
    localparam logic [6:0] FA_INT_CTRL = 7'h0B;
    // general purpose cells
    localparam logic [6:0] GPR_LO = 7'h20;
    localparam logic [6:0] GPR_B1_HI = 7'h3F;
    localparam logic [6:0] GPR_SHARED = 7'h70;

    // ------------------------------------------------------------------
    // core status bit positions and register write masks
    // ------------------------------------------------------------------
    localparam int ST_IND_BANK = 7;
    localparam int ST_BANK_HI = 6;
    localparam int ST_BANK_LO = 5;
    localparam int ST_WDT_EXP = 4;
    localparam int ST_SLEEP = 3;
    localparam int ST_ZERO = 2;
    localparam logic [7:0] STAT_WMASK = 8'hE7;
    localparam logic [7:0] PCH_WMASK = 8'h1F;
    localparam logic [7:0] FULL_WMASK = 8'hFF;

    // ------------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------------
    localparam logic [7:0] STAT_POR = 8'h18;
    localparam logic [7:0] POINTER_POR = 8'h00;
    localparam logic [7:0] INT_CTRL_RST = 8'h00;
    localparam logic [4:0] PC_HIGH_RST = 5'h00;
    localparam logic [12:0] PC_RST = 13'h0000;
    localparam logic [13:0] INSTR_RST = 14'h0000;
    localparam logic [7:0] BYTE_RST = 8'h00;

    // ------------------------------------------------------------------
    // instruction classes and file operations
    // ------------------------------------------------------------------
    localparam logic [1:0] CL_FILE = 2'b00;
    localparam logic [1:0] CL_JUMP = 2'b10;
    localparam logic [1:0] CL_LIT = 2'b11;
    localparam logic [3:0] FN_STORE_W = 4'h0;
    localparam logic [3:0] FN_DEC = 4'h3;
    localparam logic [3:0] FN_MOVE = 4'h8;
    localparam logic [3:0] FN_INVERT = 4'h9;
    localparam logic [3:0] FN_INC = 4'hA;

endpackage : core_pkg

`default_nettype wire

// ===== design/ram_port_if.sv
// two-port access bundle between the core and its cell array
// assumes both ports run on the core clock; read is combinational
`default_nettype none

interface ram_port_if;
    logic [6:0] a_addr;
    logic a_we;
    logic [7:0] a_wdata;
    logic [7:0] a_rdata;
    logic [6:0] b_addr;
    logic b_we;
    logic [7:0] b_wdata;
    logic [7:0] b_rdata;

    modport ctrl (
        output a_addr, a_we, a_wdata, b_addr, b_we, b_wdata,
        input a_rdata, b_rdata
    );
    modport mem (
        input a_addr, a_we, a_wdata, b_addr, b_we, b_wdata,
        output a_rdata, b_rdata
    );
endinterface : ram_port_if

`default_nettype wire

// ===== design/phase_gen.sv
// four-phase sequencer for the instruction cycle
// assumes the clock runs free; reset returns it to the first phase
`default_nettype none

module phase_gen
    import core_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    output phase_e phase_o
);
    phase_e phase_next;

    // ------------------------------------------------------------------
    // divide by four, repeating without end
    // ------------------------------------------------------------------
    always_comb begin
        case (phase_o)
            PH_ONE: phase_next = PH_TWO;
            PH_TWO: phase_next = PH_THREE;
            PH_THREE: phase_next = PH_FOUR;
            PH_FOUR: phase_next = PH_ONE;
            default: phase_next = PH_ONE;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            phase_o <= PH_ONE;
        end else begin
            phase_o <= phase_next;
        end
    end
endmodule : phase_gen

`default_nettype wire

// ===== design/gpr_ram.sv
// static cell array with two write and two read ports
// assumes port a (core) wins a same-cell write against port b
`default_nettype none

module gpr_ram #(
    parameter int DEPTH = 128
) (
    input wire logic core_clk_i,
    ram_port_if.mem ram
);
    logic [7:0] cells [DEPTH];

    // ------------------------------------------------------------------
    // cells keep their value across every reset
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (ram.b_we) begin
            cells[ram.b_addr] <= ram.b_wdata;
        end
        if (ram.a_we) begin
            cells[ram.a_addr] <= ram.a_wdata;
        end
    end

    assign ram.a_rdata = cells[ram.a_addr];
    assign ram.b_rdata = cells[ram.b_addr];
endmodule : gpr_ram

`default_nettype wire

// ===== design/core_phase_pipeline_sfr.sv
// core sequencer: four-phase pipeline, program counter and core registers
// assumes program memory answers combinationally within one phase and a
// register port master that never issues read and write together
`default_nettype none

module core_phase_pipeline_sfr
    import core_pkg::*;
#(
    parameter int PC_W = 13,
    parameter int INSTR_W = 14,
    parameter int RAM_DEPTH = 128
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic power_on_i,
    input wire logic wdt_reset_i,
    input wire logic [INSTR_W-1:0] prog_data_i,
    output logic [PC_W-1:0] prog_addr_o,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output phase_e phase_o,
    output logic [INSTR_W-1:0] instr_latch_o,
    output logic [7:0] work_o
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [PC_W-1:0] pc_reg;
    logic [PC_W-1:0] prog_addr_reg;
    logic [INSTR_W-1:0] fetch_buf_reg;
    logic fetch_valid_reg;
    logic [INSTR_W-1:0] instr_latch_reg;
    logic exec_valid_reg;
    logic [7:0] operand_reg;
    logic [7:0] work_reg;
    logic flush_pend_reg;
    logic [7:0] status_reg;
    logic [7:0] pointer_reg;
    logic [4:0] pc_high_reg;
    logic [7:0] int_ctrl_reg;
    logic [7:0] reg_rdata_reg;
    logic [7:0] status_next;
    logic [7:0] pointer_next;
    logic [7:0] pc_high_next;
    logic [7:0] int_ctrl_next;

    ram_port_if ram ();

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // cell index for a full file address, bit 7 flags a hit;
    // bank one in the shared range folds back onto bank zero
    function automatic logic [7:0] gpr_slot(input logic [7:0] a);
        logic [6:0] lo;
        lo = a[6:0];
        if (lo >= GPR_SHARED) begin
            return {1'b1, lo};
        end else if (!a[7] && lo >= GPR_LO) begin
            return {1'b1, lo};
        end else if (a[7] && lo >= GPR_LO && lo <= GPR_B1_HI) begin
            return {1'b1, 7'(lo - GPR_LO)};
        end
        return 8'h00;
    endfunction : gpr_slot

    // effective address; bit 8 marks the indirect port pointing at itself
    function automatic logic [8:0] resolve(input logic [7:0] a,
                                           input logic [7:0] ptr);
        if (a[6:0] == FA_INDIRECT) begin
            return {(ptr[6:0] == FA_INDIRECT), ptr};
        end
        return {1'b0, a};
    endfunction : resolve

    // read of any location; the bank bit is ignored for core registers
    function automatic logic [7:0] read_loc(input logic [8:0] res,
                                            input logic [7:0] ram_q);
        logic [7:0] slot;
        logic [7:0] v;
        slot = gpr_slot(res[7:0]);
        v = 8'h00;
        if (res[8]) begin
            v = 8'h00;
        end else if (slot[7]) begin
            v = ram_q;
        end else begin
            case (res[6:0])
                FA_PC_LOW: v = pc_reg[7:0];
                FA_CORE_STAT: v = status_reg;
                FA_POINTER: v = pointer_reg;
                FA_PC_HIGH: v = {3'b000, pc_high_reg};
                FA_INT_CTRL: v = int_ctrl_reg;
                default: v = 8'h00;
            endcase
        end
        return v;
    endfunction : read_loc

    // masked write merge; the core port is applied last so it wins
    function automatic logic [7:0] merge(input logic [7:0] old,
                                         input logic c_hit,
                                         input logic [7:0] c_d,
                                         input logic s_hit,
                                         input logic [7:0] s_d,
                                         input logic [7:0] m);
        logic [7:0] v;
        v = old;
        if (s_hit) begin
            v = (v & ~m) | (s_d & m);
        end
        if (c_hit) begin
            v = (v & ~m) | (c_d & m);
        end
        return v;
    endfunction : merge

    // ------------------------------------------------------------------
    // phase sequencer
    // ------------------------------------------------------------------
    phase_gen u_phase (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .phase_o(phase_o)
    );

    wire logic ph1 = (phase_o == PH_ONE);
    wire logic ph2 = (phase_o == PH_TWO);
    wire logic ph4 = (phase_o == PH_FOUR);

    // ------------------------------------------------------------------
    // instruction decode
    // ------------------------------------------------------------------
    wire logic [1:0] op_class = instr_latch_reg[13:12];
    wire logic [3:0] op_fn = instr_latch_reg[11:8];
    wire logic dest_file = instr_latch_reg[7];
    wire logic is_file = exec_valid_reg && op_class == CL_FILE;
    wire logic is_jump = exec_valid_reg && op_class == CL_JUMP;
    wire logic is_lit = exec_valid_reg && op_class == CL_LIT;
    wire logic is_store = op_fn == FN_STORE_W;
    wire logic fn_known = is_store || op_fn == FN_DEC
        || op_fn == FN_MOVE || op_fn == FN_INVERT || op_fn == FN_INC;

    // result of the file operation: the working register for a store, else from the operand read in phase two
    wire logic [7:0] alu_res =
        is_store ? work_reg :
        op_fn == FN_INC ? 8'(operand_reg + 8'h01) :
        op_fn == FN_DEC ? 8'(operand_reg - 8'h01) :
        op_fn == FN_INVERT ? ~operand_reg : operand_reg;

    // ------------------------------------------------------------------
    // core data path addressing
    // ------------------------------------------------------------------
    wire logic [7:0] core_dir_addr =
        {status_reg[ST_BANK_LO], instr_latch_reg[6:0]};
    wire logic [8:0] core_res = resolve(core_dir_addr, pointer_reg);
    wire logic [7:0] core_slot = gpr_slot(core_res[7:0]);
    logic [7:0] core_rdata; // process, so register changes re-evaluate
    always_comb core_rdata = read_loc(core_res, ram.a_rdata);

    // writes land in phase four only; self-indirect writes are dropped
    wire logic core_we = ph4 && is_file && fn_known
        && (dest_file || is_store) && !core_res[8];
    wire logic core_sfr_we = core_we && !core_slot[7];
    wire logic w_we = ph4 && (is_lit
        || (is_file && fn_known && !dest_file && !is_store));
    wire logic z_we = ph4 && is_file && fn_known && !is_store;

    // ------------------------------------------------------------------
    // register port addressing
    // ------------------------------------------------------------------
    wire logic [8:0] sw_res = resolve(reg_addr_i, pointer_reg);
    wire logic [7:0] sw_slot = gpr_slot(sw_res[7:0]);
    logic [7:0] sw_rdata;
    always_comb sw_rdata = read_loc(sw_res, ram.b_rdata);
    wire logic sw_sfr_we = reg_wr_i && !sw_res[8] && !sw_slot[7];

    // ------------------------------------------------------------------
    // cell array ports
    // ------------------------------------------------------------------
    assign ram.a_addr = core_slot[6:0];
    assign ram.a_we = core_we && core_slot[7];
    assign ram.a_wdata = alu_res;
    assign ram.b_addr = sw_slot[6:0];
    assign ram.b_we = reg_wr_i && !sw_res[8] && sw_slot[7];
    assign ram.b_wdata = reg_wdata_i;

    gpr_ram #(
        .DEPTH(RAM_DEPTH)
    ) u_ram (
        .core_clk_i(core_clk_i),
        .ram(ram.mem)
    );

    // ------------------------------------------------------------------
    // special register write decode
    // ------------------------------------------------------------------
    wire logic c_stat = core_sfr_we && core_res[6:0] == FA_CORE_STAT;
    wire logic s_stat = sw_sfr_we && sw_res[6:0] == FA_CORE_STAT;
    wire logic c_ptr = core_sfr_we && core_res[6:0] == FA_POINTER;
    wire logic s_ptr = sw_sfr_we && sw_res[6:0] == FA_POINTER;
    wire logic c_pch = core_sfr_we && core_res[6:0] == FA_PC_HIGH;
    wire logic s_pch = sw_sfr_we && sw_res[6:0] == FA_PC_HIGH;
    wire logic c_int = core_sfr_we && core_res[6:0] == FA_INT_CTRL;
    wire logic s_int = sw_sfr_we && sw_res[6:0] == FA_INT_CTRL;
    wire logic c_pcl = core_sfr_we && core_res[6:0] == FA_PC_LOW;
    wire logic s_pcl = sw_sfr_we && sw_res[6:0] == FA_PC_LOW;

    // expiry and sleep bits are read-only; the two reserved bank bits
    // are stored as written and steer nothing here
    always_comb begin
        status_next = merge(status_reg, c_stat, alu_res,
                            s_stat, reg_wdata_i, STAT_WMASK);
        if (z_we) begin
            status_next[ST_ZERO] = (alu_res == 8'h00);
        end
    end

    // upper three bits of the high latch are not implemented
    assign pointer_next = merge(pointer_reg, c_ptr, alu_res,
                                s_ptr, reg_wdata_i, FULL_WMASK);
    assign pc_high_next = merge({3'b000, pc_high_reg}, c_pch, alu_res,
                                s_pch, reg_wdata_i, PCH_WMASK);
    assign int_ctrl_next = merge(int_ctrl_reg, c_int, alu_res,
                                 s_int, reg_wdata_i, FULL_WMASK);

    // ------------------------------------------------------------------
    // counter loads
    // ------------------------------------------------------------------
    wire logic [PC_W-1:0] jump_target =
        {pc_high_reg[4:3], instr_latch_reg[10:0]};
    wire logic [PC_W-1:0] core_pcl_target = {pc_high_reg, alu_res};
    wire logic [PC_W-1:0] sw_pcl_target = {pc_high_reg, reg_wdata_i};
    wire logic branch_take = ph4 && (is_jump || c_pcl);
    wire logic [PC_W-1:0] branch_target =
        is_jump ? jump_target : core_pcl_target;
    wire logic sw_pc_load = s_pcl && !branch_take;
    // a software load mid-fetch must also kill the word in flight
    wire logic discard = branch_take || flush_pend_reg || sw_pc_load;

    // ------------------------------------------------------------------
    // reset values per cause
    // ------------------------------------------------------------------
    // watchdog clears expiry and sets sleep; pin reset keeps both
    wire logic [7:0] status_rst = {3'b000,
        wdt_reset_i ? 1'b0 : status_reg[ST_WDT_EXP],
        wdt_reset_i ? 1'b1 : status_reg[ST_SLEEP],
        status_reg[2:0]};

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pc_high_reg <= PC_HIGH_RST;
            if (power_on_i) begin
                status_reg <= STAT_POR;
                pointer_reg <= POINTER_POR;
                int_ctrl_reg <= INT_CTRL_RST;
            end else begin
                status_reg <= status_rst;
                int_ctrl_reg <= {INT_CTRL_RST[7:1], int_ctrl_reg[0]};
            end
        end else begin
            status_reg <= status_next;
            pointer_reg <= pointer_next;
            pc_high_reg <= pc_high_next[4:0];
            int_ctrl_reg <= int_ctrl_next;
        end
    end

    // ------------------------------------------------------------------
    // fetch side: counter, program address, prefetch buffer
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pc_reg <= PC_RST;
            prog_addr_reg <= PC_RST;
            fetch_buf_reg <= INSTR_RST;
            fetch_valid_reg <= 1'b0;
            flush_pend_reg <= 1'b0;
        end else begin
            if (branch_take) begin
                pc_reg <= branch_target;
            end else if (sw_pc_load) begin
                pc_reg <= sw_pcl_target;
            end else if (ph1) begin
                pc_reg <= PC_W'(pc_reg + 1'b1);
            end
            if (ph1) begin
                prog_addr_reg <= pc_reg;
            end
            if (ph4) begin
                fetch_buf_reg <= prog_data_i;
                fetch_valid_reg <= !discard;
                flush_pend_reg <= 1'b0;
            end else if (sw_pc_load) begin
                flush_pend_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // execute side: latch, operand, working register
    // ------------------------------------------------------------------
    // the latch loads while the next fetch starts: the overlap that
    // gives one cycle per plain instruction
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            instr_latch_reg <= INSTR_RST;
            exec_valid_reg <= 1'b0;
            operand_reg <= BYTE_RST;
            work_reg <= BYTE_RST;
        end else begin
            if (ph1) begin
                instr_latch_reg <= fetch_buf_reg;
                exec_valid_reg <= fetch_valid_reg;
            end
            if (ph2) begin
                operand_reg <= core_rdata;
            end
            if (w_we) begin
                work_reg <= is_lit ? instr_latch_reg[7:0] : alu_res;
            end
        end
    end

    // ------------------------------------------------------------------
    // register port read data, valid only the cycle after the strobe
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            reg_rdata_reg <= BYTE_RST;
        end else begin
            reg_rdata_reg <= reg_rd_i ? sw_rdata : 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign prog_addr_o = prog_addr_reg;
    assign reg_rdata_o = reg_rdata_reg;
    assign instr_latch_o = instr_latch_reg;
    assign work_o = work_reg;

endmodule : core_phase_pipeline_sfr

`default_nettype wire

// ===== verification/prog_mem_model.sv
// program memory stand-in: a short fixed table read combinationally
// assumes the fetch address holds for a whole instruction cycle
`default_nettype none

module prog_mem_model (
    input wire logic [12:0] addr_i,
    output logic [13:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // -------------------------------------------------------------
    // program table
    // -------------------------------------------------------------
    // lit 3C, store to 20, jump 5, inc 20 (must be flushed), lit 11
    logic [13:0] rom [0:7] = '{14'h303C, 14'h00A0, 14'h2005, 14'h0A20,
        14'h1000, 14'h3011, 14'h2006, 14'h1000};

    // answers at once, so the word is settled at the phase-four edge
    assign data_o = (addr_i < 13'h0008) ? rom[addr_i[2:0]]
        : 14'h1000;

endmodule : prog_mem_model

`default_nettype wire

// ===== verification/core_phase_pipeline_sfr_properties.sv
// timing checks on the core sequencer, from its top-level ports only
// assumes one clock domain and a synchronous active-high reset
`default_nettype none

module core_phase_pipeline_sfr_properties
    import core_pkg::*;
#(
    parameter int PC_W = 13,
    parameter int INSTR_W = 14
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [INSTR_W-1:0] prog_data_i,
    input wire logic [PC_W-1:0] prog_addr_o,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire phase_e phase_o,
    input wire logic [INSTR_W-1:0] instr_latch_o,
    input wire logic [7:0] work_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // class of the instruction now executing
    wire logic [1:0] cls = instr_latch_o[13:12];

    phase_step_a: assert property (
        !$past(rst_i) |-> 2'(phase_o - $past(phase_o)) == 2'h1)
        else $error("phase");
    fetch_hold_a: assert property (
        phase_o != PH_ONE |=> $stable(prog_addr_o)) else $error("addr moved");
    fetch_next_a: assert property (
        phase_o == PH_ONE && cls == CL_LIT |=>
        prog_addr_o == $past(prog_addr_o) + 1'b1) else $error("no step");
    jump_target_a: assert property (
        phase_o == PH_ONE && cls == CL_JUMP |=>
        prog_addr_o[10:0] == $past(instr_latch_o[10:0])) else $error("jump");
    latch_hold_a: assert property (
        phase_o != PH_ONE |=> $stable(instr_latch_o)) else $error("latch");
    fetch_capture_a: assert property (
        phase_o == PH_FOUR && cls == CL_LIT |=> ##1
        instr_latch_o == $past(prog_data_i, 2)) else $error("capture");
    work_hold_a: assert property (
        phase_o != PH_FOUR |=> $stable(work_o)) else $error("early write");
    literal_load_a: assert property (
        phase_o == PH_FOUR && cls == CL_LIT |=>
        work_o == $past(instr_latch_o[7:0])) else $error("literal");
    unmapped_zero_a: assert property (
        reg_rd_i && reg_addr_i[6:0] inside {7'h01, [7'h05:7'h09],
        [7'h0C:7'h1F]} |=> reg_rdata_o == 8'h00) else $error("unmapped");

endmodule : core_phase_pipeline_sfr_properties

bind core_phase_pipeline_sfr core_phase_pipeline_sfr_properties #(
    .PC_W(PC_W), .INSTR_W(INSTR_W)) i_props (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .prog_data_i(prog_data_i), .prog_addr_o(prog_addr_o),
    .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i), .phase_o(phase_o),
    .reg_rdata_o(reg_rdata_o), .instr_latch_o(instr_latch_o),
    .work_o(work_o));

`default_nettype wire

// ===== verification/core_phase_pipeline_sfr_tb.sv
// self-checking bench: register map, resets and the fetch pipeline
// assumes prog_mem_model holds the short program from address zero
`default_nettype none

module core_phase_pipeline_sfr_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk_i = 0, rst_i = 1, power_on_i = 1, wdt_reset_i = 0;
    logic reg_wr_i = 0, reg_rd_i = 0, saw_bad = 0;
    logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o, work_o;
    logic [13:0] prog_data_i, instr_latch_o;
    logic [12:0] prog_addr_o;
    core_pkg::phase_e phase_o;
    int fails = 0, compares = 0, seed = 64, a;
    int mdl [256];
    int core_a [4] = '{3, 4, 10, 11};
    int unm [8] = '{1, 5, 9, 'h0C, 'h1F, 'hC0, 'hEF, 'h85};

    always #4 core_clk_i = ~core_clk_i;

    core_phase_pipeline_sfr i_core_phase_pipeline_sfr (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .power_on_i(power_on_i),
        .wdt_reset_i(wdt_reset_i), .prog_data_i(prog_data_i),
        .prog_addr_o(prog_addr_o), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .phase_o(phase_o),
        .instr_latch_o(instr_latch_o), .work_o(work_o));
    prog_mem_model i_prog_mem_model (.addr_i(prog_addr_o),
        .data_o(prog_data_i));

    // the flushed increment would leave 3D in the working register
    always @(posedge core_clk_i) if (work_o === 8'h3D) saw_bad <= 1;

    // -------------------------------------------------------------
    // model and bus tasks
    // -------------------------------------------------------------
    // model index of an address, -1 where nothing is mapped
    function automatic int ca(input int x);
        int b;
        if (x % 128 == 0) x = mdl[4];
        b = x % 128;
        if (b inside {2, 3, 4, 10, 11}) return b;
        if (x >= 'hF0) return b;
        if (b >= 'h20 && x < 'hC0) return x;
        return -1;
    endfunction : ca

    task automatic chk(input string n, input int e, input logic [7:0] g);
        compares++;
        if (g !== 8'(e)) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, 8'(e), g);
        end
    endtask : chk

    task automatic wr(input int x, input int d);
        int i;
        i = ca(x);
        reg_wr_i <= 1;
        reg_addr_i <= 8'(x);
        reg_wdata_i <= 8'(d);
        @(posedge core_clk_i);
        reg_wr_i <= 0;
        @(posedge core_clk_i);
        // status bits 4:3 and high latch bits 7:5 ignore writes
        if (i == 3) mdl[3] = (mdl[3] & 'h18) | (d & 'hE7);
        else if (i == 10) mdl[10] = d & 'h1F;
        else if (i >= 0) mdl[i] = d & 'hFF;
    endtask : wr

    task automatic rd(input int x);
        int i;
        i = ca(x);
        reg_rd_i <= 1;
        reg_addr_i <= 8'(x);
        @(posedge core_clk_i);
        reg_rd_i <= 0;
        @(negedge core_clk_i);
        chk("read data", i < 0 ? 0 : mdl[i], reg_rdata_o);
        @(posedge core_clk_i);
    endtask : rd

    task automatic do_rst(input bit po, input bit wd);
        rst_i <= 1;
        power_on_i <= po;
        wdt_reset_i <= wd;
        repeat (2) @(posedge core_clk_i);
        rst_i <= 0;
        power_on_i <= 0;
        wdt_reset_i <= 0;
        mdl[10] = 0;
        mdl['h20] = 'h3C;
        mdl[11] = po ? 0 : mdl[11] & 1;
        if (po) mdl[4] = 0;
        mdl[3] = po ? 'h18 : wd ? (mdl[3] & 7) | 8 : mdl[3] & 'h1F;
    endtask : do_rst

    task automatic summarize();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize

    // -------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------
    initial begin
        do_rst(1, 0);
        foreach (core_a[k]) begin
            rd(core_a[k]);
            rd(core_a[k] + 'h80);
        end
        foreach (unm[k]) begin
            wr(unm[k], 'hFF);
            rd(unm[k]);
        end
        wr(3, 'h07);
        rd('h83);
        wr('h8A, 'hFF);
        rd(10);
        repeat (8) begin
            a = 'h21 + $unsigned($random(seed)) % 'h5F;
            if ($random(seed) % 2 != 0 && a < 'h40) a += 'h80;
            wr(a, $random(seed));
            rd(a);
        end
        wr('hF3, 'h5C);
        rd('h73);
        wr(4, 'h25);
        wr(0, 'hA5);
        rd('h25);
        rd('h80);
        wr(4, 'h5A);
        wr(11, 'hFF);
        rd('h20);
        chk("work", 'h11, work_o);
        for (int k = 0; k < 3; k++) begin
            do_rst(k == 2, k == 0);
            @(negedge core_clk_i);
            chk("work", 0, work_o);
            @(posedge core_clk_i);
            foreach (core_a[j]) rd(core_a[j]);
            repeat (40) @(posedge core_clk_i);
            chk("work", 'h11, work_o);
        end
        wr(4, 0);
        rd(0);
        chk("flushed", 0, 8'(saw_bad));
        summarize();
    end

    // cut a hang short
    initial begin
        #100000;
        fails++;
        summarize();
    end

endmodule : core_phase_pipeline_sfr_tb

`default_nettype wire
